// File: pkg/navigator_pkg.sv
// constants, types and carriers shared by the device monitor navigator
// assumes a single 50 MHz system clock; all slower rates come from a tick enable
package navigator_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int HOLD_MS = 1000;
	localparam int HOLD_TICKS = (HOLD_MS * 1000 + TICK_US - 1) / TICK_US;
	localparam int REPEAT_MS = 100;
	localparam int REPEAT_TICKS = REPEAT_MS * 1000 / TICK_US;

	localparam int BTN_ESC = 0;
	localparam int BTN_MINUS = 1;
	localparam int BTN_PLUS = 2;
	localparam int BTN_OK = 3;

	localparam logic [2:0] MENU_MONITOR = 3'h0;
	localparam logic [2:0] MENU_LAST = 3'h4;
	localparam logic [15:0] FIRST_SHOWN = 16'h0001;
	localparam logic [15:0] WORD_STEP = 16'h0001;
	localparam logic [15:0] PAIR_STEP = 16'h0002;
	localparam logic [15:0] XY_POINTS = 16'h0008;
	localparam logic [15:0] RELAY_POINTS = 16'h000a;
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_DOT = 8'h2e;
	localparam logic [7:0] CHAR_SPACE = 8'h20;

	typedef enum logic [2:0] {SCR_LOAD, SCR_TOP, SCR_MENU, SCR_TYPE, SCR_MONITOR, SCR_TEST} screen_t;

	typedef enum logic [3:0] {DEV_D, DEV_DD, DEV_T, DEV_C, DEV_R, DEV_DR, DEV_ER, DEV_DER,
		DEV_X, DEV_Y, DEV_M, DEV_S} dev_t;

	localparam int DEV_COUNT = 12;
	localparam logic [3:0] DEV_LAST_INDEX = 4'hb;
	// last listed number (bit types: start of the last line), order S down to D
	localparam logic [DEV_COUNT-1:0][15:0] DEV_LAST_DEFAULT = {16'h03de, 16'h03de, 16'h0078, 16'h0078,
		16'h00fe, 16'h00ff, 16'h00fe, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00fe, 16'h00ff};

	typedef struct packed {
		logic contact;
		logic reset_on;
		logic count_up;
		logic wide_counter;
		logic used;
		logic [9:0] points;
	} mon_status_t;

	typedef struct packed {
		screen_t screen;
		logic [2:0] menu_cursor;
		dev_t type_cursor;
		logic [15:0] top_num;
		logic [15:0] cursor_num;
		logic [1:0] cursor_row;
		logic [3:0] line_points;
		logic contact_mark;
		logic reset_mark;
		logic show_dir;
		logic dir_mark;
		logic set_dashes;
		logic pair_view;
		logic [15:0] upper_num;
		logic [15:0] lower_num;
		logic [9:0][7:0] chars;
	} view_t;

endpackage

// File: hdl/device_monitor_navigator.sv
// screen navigation for the display module's device monitor, driven by four buttons
// assumes an outside store answers NV reads in the same cycle and supplies live device status
// Overview of operation
// - confirm on the monitor/test menu item opens device-type selection
// - escape on the menu returns to the top time screen
// - plus/minus move among device types; escape returns to the menu
// - confirm opens the type's monitor; escape on a monitor returns to type selection
// - first power-up starts every type's listing at device number one
// - later power-ups show the last viewed number, saved per type
// - minus scrolls up; at the first number it wraps to the last
// - plus scrolls down; at the last number it wraps to the first
// - plus or minus held one second switches to fast repeated scrolling
// - word types move the cursor one entry; bit types scroll line by line
// - confirm held one second enters test mode, except for the input type
// - unused timers and counters show dashes in the setting value
// - direction mark only for wide counters: filled up, blank down
// - input and output lines hold eight points, labelled by the first number
// - relay and state lines hold ten points each
// - an on point shows its number's last digit, an off point a dot
// - a 32-bit pair labels the odd number upper and the even lower
// - no monitoring of program-memory file registers or index registers
// - menu minus/plus scroll, ignored at the top and bottom respectively
`timescale 1ns/10ps
module device_monitor_navigator
	import navigator_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES,
	parameter int HOLD_LEN = HOLD_TICKS,
	parameter int REPEAT_LEN = REPEAT_TICKS,
	parameter logic [DEV_COUNT-1:0][15:0] LAST_NUM = DEV_LAST_DEFAULT
)
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic ESCAPE_BUTTON,
	input wire logic MINUS_BUTTON,
	input wire logic PLUS_BUTTON,
	input wire logic CONFIRM_BUTTON,
	input wire mon_status_t MON_STATUS,
	output dev_t NV_RD_TYPE,
	input wire logic [15:0] NV_RD_NUM,
	input wire logic NV_RD_BLANK,
	output logic NV_WR,
	output dev_t NV_WR_TYPE,
	output logic [15:0] NV_WR_NUM,
	output view_t VIEW
);

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] samp;
		logic [3:0] deb;
		logic [15:0] tick;
		logic [15:0] hold;
		logic [15:0] rep;
		logic fast;
		logic [3:0] evt;
		logic ok_long;
		screen_t scr;
		logic [2:0] menu;
		dev_t sel;
		logic [15:0] num;
		logic [15:0] top;
		logic [3:0] ld;
		logic nv_wr;
		logic [DEV_COUNT-1:0][15:0] saved;
		view_t view;
	} state_t;

	state_t q;
	state_t next;
	logic [9:0][7:0] chars_w;
	logic [15:0] step;
	logic [15:0] last;
	logic [15:0] span;
	logic bit_type;
	logic tick_en;

	function automatic logic [15:0] step_of(input dev_t t);
		unique case (t)
			DEV_X, DEV_Y: step_of = XY_POINTS;
			DEV_M, DEV_S: step_of = RELAY_POINTS;
			DEV_DD, DEV_DR, DEV_DER: step_of = PAIR_STEP;
			DEV_D, DEV_T, DEV_C, DEV_R, DEV_ER: step_of = WORD_STEP;
		endcase
	endfunction

	assign step = step_of(q.sel);
	assign last = LAST_NUM[q.sel];
	assign span = step + step + step;
	assign bit_type = q.sel inside {DEV_X, DEV_Y, DEV_M, DEV_S};
	assign tick_en = (q.tick == 16'(TICK_LEN - 1));

	// one character per point; lines are aligned so point i carries last digit i
	for (genvar i = 0; i < 10; i++)
	begin : g_point
		assign chars_w[i] = (16'(i) >= step) ? CHAR_SPACE :
			(MON_STATUS.points[i] ? CHAR_ZERO + 8'(i) : CHAR_DOT);
	end

	always_comb
	begin
		next = q;
		next.evt = 4'h0;
		next.ok_long = 1'b0;
		next.nv_wr = 1'b0;

		// only the first stage looks at the pins; the second stage and later see the stage before
		next.s1 = {CONFIRM_BUTTON, PLUS_BUTTON, MINUS_BUTTON, ESCAPE_BUTTON};
		next.s2 = q.s1;
		next.tick = tick_en ? 16'h0000 : q.tick + 16'h0001;
		if (tick_en)
		begin
			// accept a level only after two equal tick samples
			next.samp = q.s2;
			for (int b = 0; b < 4; b++)
			begin
				if (q.s2[b] == q.samp[b])
					next.deb[b] = q.s2[b];
			end
		end
		next.evt = next.deb & ~q.deb;

		// hold timing shared by minus, plus and confirm; one held button at a time
		if (!(q.deb[BTN_MINUS] | q.deb[BTN_PLUS] | q.deb[BTN_OK]))
		begin
			next.hold = 16'h0000;
			next.rep = 16'h0000;
			next.fast = 1'b0;
		end
		else if (tick_en && !q.fast)
		begin
			next.hold = q.hold + 16'h0001;
			if (q.hold == 16'(HOLD_LEN - 1))
			begin
				next.fast = 1'b1;
				next.ok_long = q.deb[BTN_OK];
			end
		end
		else if (tick_en)
		begin
			next.rep = (q.rep == 16'(REPEAT_LEN - 1)) ? 16'h0000 : q.rep + 16'h0001;
			if (q.rep == 16'(REPEAT_LEN - 1))
			begin
				next.evt[BTN_MINUS] = q.deb[BTN_MINUS];
				next.evt[BTN_PLUS] = q.deb[BTN_PLUS];
			end
		end

		unique case (q.scr)
			SCR_LOAD:
			begin
				// pull each type's remembered number out of the store
				next.saved[q.ld] = NV_RD_BLANK ? FIRST_SHOWN : NV_RD_NUM;
				next.ld = q.ld + 4'h1;
				if (q.ld == DEV_LAST_INDEX)
					next.scr = SCR_TOP;
			end
			SCR_TOP:
			begin
				if (q.evt[BTN_OK])
					next.scr = SCR_MENU;
			end
			SCR_MENU:
			begin
				if (q.evt[BTN_ESC])
					next.scr = SCR_TOP;
				else if (q.evt[BTN_OK] && q.menu == MENU_MONITOR)
					next.scr = SCR_TYPE;
				else if (q.evt[BTN_MINUS] && q.menu != 3'h0)
					next.menu = q.menu - 3'h1;
				else if (q.evt[BTN_PLUS] && q.menu != MENU_LAST)
					next.menu = q.menu + 3'h1;
			end
			SCR_TYPE:
			begin
				// the type list holds only monitorable kinds, so file and index registers never appear
				if (q.evt[BTN_ESC])
					next.scr = SCR_MENU;
				else if (q.evt[BTN_OK])
				begin
					next.scr = SCR_MONITOR;
					next.num = q.saved[q.sel];
					next.top = q.saved[q.sel];
				end
				else if (q.evt[BTN_MINUS] && q.sel != DEV_D)
					next.sel = dev_t'(q.sel - 4'h1);
				else if (q.evt[BTN_PLUS] && q.sel != DEV_S)
					next.sel = dev_t'(q.sel + 4'h1);
			end
			SCR_MONITOR:
			begin
				if (q.evt[BTN_ESC])
				begin
					next.scr = SCR_TYPE;
					next.saved[q.sel] = q.num;
					next.nv_wr = 1'b1;
				end
				else if (q.ok_long && q.sel != DEV_X)
					next.scr = SCR_TEST;
				else if (q.evt[BTN_MINUS] && bit_type)
				begin
					next.top = (q.top < step) ? last : q.top - step;
					next.num = next.top;
				end
				else if (q.evt[BTN_PLUS] && bit_type)
				begin
					next.top = (q.top + step > last) ? 16'h0000 : q.top + step;
					next.num = next.top;
				end
				else if (q.evt[BTN_MINUS])
				begin
					if (q.num < step)
					begin
						next.num = last;
						next.top = (last > span) ? last - span : 16'h0000;
					end
					else
					begin
						next.num = q.num - step;
						if (next.num < q.top)
							next.top = next.num;
					end
				end
				else if (q.evt[BTN_PLUS])
				begin
					if (q.num + step > last)
					begin
						next.num = 16'h0000;
						next.top = 16'h0000;
					end
					else
					begin
						next.num = q.num + step;
						if (next.num > q.top + span)
							next.top = q.top + step;
					end
				end
			end
			SCR_TEST:
			begin
				// editing itself lives elsewhere; only the way back is handled here
				if (q.evt[BTN_ESC])
					next.scr = SCR_MONITOR;
			end
		endcase

		next.view.screen = q.scr;
		next.view.menu_cursor = q.menu;
		next.view.type_cursor = q.sel;
		next.view.top_num = q.top;
		next.view.cursor_num = q.num;
		next.view.line_points = bit_type ? step[3:0] : 4'h0;
		if (bit_type || q.num == q.top)
			next.view.cursor_row = 2'h0;
		else if (q.num == q.top + step)
			next.view.cursor_row = 2'h1;
		else if (q.num == q.top + step + step)
			next.view.cursor_row = 2'h2;
		else
			next.view.cursor_row = 2'h3;
		next.view.contact_mark = MON_STATUS.contact;
		next.view.reset_mark = MON_STATUS.reset_on;
		next.view.show_dir = (q.sel == DEV_C) && MON_STATUS.wide_counter;
		next.view.dir_mark = (q.sel == DEV_C) && MON_STATUS.wide_counter && MON_STATUS.count_up;
		next.view.set_dashes = (q.sel inside {DEV_T, DEV_C}) && !MON_STATUS.used;
		next.view.pair_view = q.sel inside {DEV_DD, DEV_DR, DEV_DER};
		next.view.lower_num = {q.num[15:1], 1'b0};
		next.view.upper_num = {q.num[15:1], 1'b1};
		next.view.chars = bit_type ? chars_w : {10{CHAR_SPACE}};
	end

	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			q <= '0;
		else
			q <= next;
	end

	assign NV_RD_TYPE = dev_t'(q.ld);
	assign NV_WR = q.nv_wr;
	assign NV_WR_TYPE = q.sel;
	assign NV_WR_NUM = q.saved[q.sel];
	assign VIEW = q.view;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);

	property p_menu_confirm;
		(q.scr == SCR_MENU && q.evt[BTN_OK] && !q.evt[BTN_ESC] && q.menu == MENU_MONITOR) |=> q.scr == SCR_TYPE;
	endproperty
	a_menu_confirm: assert property (p_menu_confirm) else $error("menu confirm did not open type selection");

	property p_menu_escape;
		(q.scr == SCR_MENU && q.evt[BTN_ESC]) |=> q.scr == SCR_TOP ##1 VIEW.screen == SCR_TOP;
	endproperty
	a_menu_escape: assert property (p_menu_escape) else $error("menu escape did not reach top screen");

	property p_type_escape;
		(q.scr == SCR_TYPE && q.evt[BTN_ESC]) |=> q.scr == SCR_MENU && $stable(q.sel);
	endproperty
	a_type_escape: assert property (p_type_escape) else $error("type escape did not reach menu");

	property p_type_confirm;
		(q.scr == SCR_TYPE && q.evt == 4'h8) |=> q.scr == SCR_MONITOR && q.num == q.saved[q.sel];
	endproperty
	a_type_confirm: assert property (p_type_confirm) else $error("monitor opened at wrong number");

	property p_monitor_escape;
		(q.scr == SCR_MONITOR && q.evt[BTN_ESC]) |=> q.scr == SCR_TYPE && NV_WR && NV_WR_NUM == $past(q.num);
	endproperty
	a_monitor_escape: assert property (p_monitor_escape) else $error("monitor escape did not save and return");

	property p_wrap_up;
		(q.scr == SCR_MONITOR && q.evt == 4'h2 && !q.ok_long && q.num < step && !bit_type) |=> q.num == last;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("minus at first number did not wrap");

	property p_wrap_down;
		(q.scr == SCR_MONITOR && q.evt == 4'h4 && !q.ok_long && q.num + step > last && !bit_type) |=> q.num == 16'h0000;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("plus at last number did not wrap");

	property p_fast_after_hold;
		$rose(q.fast) |-> $past(q.hold) == 16'(HOLD_LEN - 1) && $past(tick_en);
	endproperty
	a_fast_after_hold: assert property (p_fast_after_hold) else $error("fast scroll began before the hold time");

	property p_no_input_test;
		q.scr == SCR_TEST |-> q.sel != DEV_X;
	endproperty
	a_no_input_test: assert property (p_no_input_test) else $error("test mode entered for input type");

	property p_dashes;
		(q.sel == DEV_T && !MON_STATUS.used) |=> VIEW.set_dashes;
	endproperty
	a_dashes: assert property (p_dashes) else $error("unused timer setting not dashed");

	property p_xy_points;
		(q.sel inside {DEV_X, DEV_Y}) |=> VIEW.line_points == 4'h8;
	endproperty
	a_xy_points: assert property (p_xy_points) else $error("input or output line not eight points");

	property p_pair_labels;
		VIEW.pair_view |-> VIEW.upper_num == VIEW.lower_num + 16'h0001 && !VIEW.lower_num[0];
	endproperty
	a_pair_labels: assert property (p_pair_labels) else $error("pair labels not odd upper, even lower");

	c_test_mode: cover property (q.scr == SCR_MONITOR ##1 q.scr == SCR_TEST);
	c_wrap_down: cover property (q.scr == SCR_MONITOR && q.evt[BTN_PLUS] ##1 q.num == 16'h0000);
	c_fast_scroll: cover property ($rose(q.fast) && q.deb[BTN_PLUS]);
	c_save: cover property (NV_WR);

endmodule

// File: verification/button_operator.sv
// operator model: presses the four front-panel buttons with contact bounce
// assumes the bench calls press from its main sequence; buttons rest low when released
`timescale 1ns/10ps
module button_operator
	import navigator_pkg::*;
(
	input wire logic sys_clk,
	output logic [3:0] buttons
);
	initial buttons = 4'h0;

	// three toggles on make and on break, like a worn contact, then a quiet gap
	task automatic press(input int b, input int len);
		begin
			repeat (3)
			begin
				@(negedge sys_clk);
				buttons[b] = ~buttons[b];
			end
			repeat (len) @(negedge sys_clk);
			repeat (3)
			begin
				@(negedge sys_clk);
				buttons[b] = ~buttons[b];
			end
			repeat (24) @(negedge sys_clk);
		end
	endtask
endmodule

// File: verification/device_monitor_navigator_test.sv
// self-checking bench for the device monitor navigator
// assumes the operator model drives the buttons and this bench acts as the number store
`timescale 1ns/10ps
module device_monitor_navigator_test
	import navigator_pkg::*;
;
	typedef struct {int sel; logic [15:0] val;} note_t;
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [3:0] btn;
	mon_status_t status = '0;
	dev_t rd_type;
	dev_t wr_type;
	logic [15:0] rd_num;
	logic [15:0] wr_num;
	logic wr;
	view_t view;
	logic [15:0] nv [DEV_COUNT];
	logic nv_blank = 1'b1;
	note_t notes[$];
	note_t nt;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 99;

	always #10 SYS_CLK = ~SYS_CLK;
	// past the twelve load cycles the read index leaves the table; feed zero there
	assign rd_num = (rd_type < DEV_COUNT) ? nv[rd_type] : 16'h0000;
	always @(posedge SYS_CLK)
		if (wr === 1'b1)
			nv[wr_type] <= wr_num;

	button_operator u_button_operator (.sys_clk(SYS_CLK), .buttons(btn));
	device_monitor_navigator #(.TICK_LEN(4), .HOLD_LEN(5), .REPEAT_LEN(2)) u_device_monitor_navigator (
		.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ESCAPE_BUTTON(btn[BTN_ESC]), .MINUS_BUTTON(btn[BTN_MINUS]),
		.PLUS_BUTTON(btn[BTN_PLUS]), .CONFIRM_BUTTON(btn[BTN_OK]), .MON_STATUS(status),
		.NV_RD_TYPE(rd_type), .NV_RD_NUM(rd_num), .NV_RD_BLANK(nv_blank), .NV_WR(wr),
		.NV_WR_TYPE(wr_type), .NV_WR_NUM(wr_num), .VIEW(view));

	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cmp_screen(input screen_t exp, input screen_t got);
		n_checks++;
		if (exp !== got)
		begin
			failures++;
			$display("BAD screen expected %s seen %s", exp.name(), got.name());
		end
	endtask

	task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (exp !== got)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] pick(input int sel);
		case (sel)
			1: return {13'h0000, view.menu_cursor};
			2: return {12'h000, view.type_cursor};
			3: return view.cursor_num;
			4: return view.upper_num;
			5: return view.lower_num;
			6: return {12'h000, view.line_points};
			7: return {10'h000, view.contact_mark, view.reset_mark, view.show_dir, view.dir_mark,
				view.set_dashes, view.pair_view};
			18: return {14'h0000, view.cursor_row};
			19: return view.top_num;
			20: return {15'h0000, view.cursor_num > 16'h0002};
			default: return {8'h00, view.chars[sel-8]};
		endcase
	endfunction

	// watcher: a little after each edge, settle every queued note against the view
	always @(posedge SYS_CLK)
	begin
		#1;
		while (notes.size() > 0)
		begin
			nt = notes.pop_front();
			if (nt.sel == 0)
				cmp_screen(screen_t'(nt.val[2:0]), view.screen);
			else
				cmp_val($sformatf("view field %0d", nt.sel), nt.val, pick(nt.sel));
		end
	end

	always @(posedge SYS_CLK)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic note_it(input int sel, input logic [15:0] v);
		notes.push_back('{sel, v});
	endtask

	task automatic note_scr(input screen_t s);
		note_it(0, {13'h0000, s});
	endtask

	task automatic tap(input int b);
		u_button_operator.press(b, 9);
	endtask

	task automatic hold(input int b);
		u_button_operator.press(b, 80);
	endtask

	task automatic taps(input int b, input int n);
		repeat (n) tap(b);
	endtask

	task automatic power_up();
		// let the watcher settle any notes taken on the view before reset wipes it
		@(negedge SYS_CLK);
		RST_B = 1'b0;
		repeat (12) @(negedge SYS_CLK);
		RST_B = 1'b1;
		repeat (40) @(negedge SYS_CLK);
		note_scr(SCR_TOP);
	endtask

	// random live status, then every point of the line against its expected glyph
	task automatic check_line(input int n);
		logic [7:0] c;
		status = $random(seed);
		repeat (4) @(negedge SYS_CLK);
		note_it(6, n[15:0]);
		for (int i = 0; i < 10; i++)
		begin
			c = (i >= n) ? CHAR_SPACE : (status.points[i] ? CHAR_ZERO + i[7:0] : CHAR_DOT);
			note_it(8 + i, {8'h00, c});
		end
	endtask

	initial
	begin
		for (int i = 0; i < DEV_COUNT; i++)
			nv[i] = 16'h0000;
		power_up();
		tap(BTN_OK);
		note_scr(SCR_MENU);
		tap(BTN_MINUS);
		note_it(1, 16'h0000);
		tap(BTN_ESC);
		note_scr(SCR_TOP);
		tap(BTN_OK);
		tap(BTN_PLUS);
		note_it(1, 16'h0001);
		tap(BTN_OK);
		note_scr(SCR_MENU);
		tap(BTN_MINUS);
		tap(BTN_OK);
		note_scr(SCR_TYPE);
		tap(BTN_MINUS);
		note_it(2, {12'h000, DEV_D});
		tap(BTN_PLUS);
		note_it(2, {12'h000, DEV_DD});
		tap(BTN_OK);
		note_it(7, 16'h0001);
		note_it(5, 16'h0000);
		note_it(4, 16'h0001);
		tap(BTN_ESC);
		note_scr(SCR_TYPE);
		tap(BTN_MINUS);
		tap(BTN_OK);
		note_scr(SCR_MONITOR);
		note_it(3, FIRST_SHOWN);
		taps(BTN_MINUS, 2);
		note_it(3, DEV_LAST_DEFAULT[DEV_D]);
		note_it(19, DEV_LAST_DEFAULT[DEV_D] - 16'h0003);
		note_it(18, 16'h0003);
		tap(BTN_PLUS);
		note_it(3, 16'h0000);
		taps(BTN_PLUS, 2);
		note_it(3, 16'h0002);
		hold(BTN_OK);
		note_scr(SCR_TEST);
		tap(BTN_ESC);
		tap(BTN_ESC);
		cmp_val("stored number", 16'h0002, nv[DEV_D]);
		taps(BTN_PLUS, 3);
		tap(BTN_OK);
		status = $random(seed);
		status.wide_counter = 1'b1;
		status.used = 1'b0;
		repeat (4) @(negedge SYS_CLK);
		note_it(7, {10'h000, status.contact, status.reset_on, 1'b1, status.count_up, 2'b10});
		// the status must stand until the watcher has settled the note above
		@(negedge SYS_CLK);
		status.wide_counter = 1'b0;
		status.used = 1'b1;
		repeat (4) @(negedge SYS_CLK);
		note_it(7, {10'h000, status.contact, status.reset_on, 4'h0});
		hold(BTN_PLUS);
		note_it(20, 16'h0001);
		tap(BTN_ESC);
		taps(BTN_PLUS, 5);
		tap(BTN_OK);
		check_line(8);
		hold(BTN_OK);
		note_scr(SCR_MONITOR);
		tap(BTN_ESC);
		taps(BTN_PLUS, 2);
		tap(BTN_OK);
		check_line(10);
		nv_blank = 1'b0;
		power_up();
		taps(BTN_OK, 3);
		note_it(3, 16'h0002);
		repeat (4) @(negedge SYS_CLK);
		give_verdict();
	end
endmodule
